//--- hdl/cils_pkg.sv
// Constants, register map and carrier types of the camera I/O line and strobe timer block.
// Assumes one 200 MHz clock and software access over a plain strobe register port.
// Overview of operation
// - Only the bidirectional pin has selectable direction.
// - Software picks output line; output-only after reset.
// - Picked line drives its chosen source; off default.
// - Exposure source follows exposure window.
// - Transfer source follows USB send window.
// - Frame source follows exposure-to-readout window.
// - Wait source follows awaiting trigger.
// - Trigger during wait starts exposure after pre-exposure wait.
// - Acquisition source follows capture running.
// - User source drives software level; default low.
// - Strobe source drives strobe timer pulse.
// - Per-line inversion, also on user level.
// - Read-only readback of every line level.
// - Glitch integrator delays input; 90 ns..2 ms.
// - Edge blanking after accepted edge; 1992 ns..1999992 ns.
// - Both filters on input-only and bidirectional pins.
// - Strobe width 0 to 2000000.00 us.
// - Strobe lag 0 to 2000000.00 us.
// - Start choice: off, input pin, exposure, frame.
// - Input pin start: hardware mode, fires on faults.
// - Frame/exposure starts skip faults, any trigger.
// - Exposure start strobe lags wait plus lag.
// - Read-only strobe unit name selector.
// - Pre-exposure wait up to 2000000.00 us.
package cils_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TIME_UNIT_NS = 10;
  localparam int UNIT_CYC = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [31:0] GLITCH_DEF_NS = 32'h0000005A;
  localparam logic [31:0] GLITCH_MAX_NS = 32'h001E8480;
  localparam logic [31:0] BLANK_DEF_NS = 32'h000007C8;
  localparam logic [31:0] BLANK_MAX_NS = 32'h001E8478;
  localparam logic [31:0] TIME_MAX_UNITS = 32'h0BEBC200;
  localparam logic [31:0] STROBE_UNIT_NAME = 32'h00000000;
  localparam logic [7:0] ADR_LINE_PICK = 8'h00;
  localparam logic [7:0] ADR_SIGNAL_CHOICE = 8'h04;
  localparam logic [7:0] ADR_PIN_DIR = 8'h08;
  localparam logic [7:0] ADR_INVERT = 8'h0C;
  localparam logic [7:0] ADR_READBACK = 8'h10;
  localparam logic [7:0] ADR_SW_LEVEL = 8'h14;
  localparam logic [7:0] ADR_INTEGRATOR = 8'h18;
  localparam logic [7:0] ADR_BLANKING = 8'h1C;
  localparam logic [7:0] ADR_STROBE_WIDTH = 8'h20;
  localparam logic [7:0] ADR_STROBE_LAG = 8'h24;
  localparam logic [7:0] ADR_STROBE_START = 8'h28;
  localparam logic [7:0] ADR_UNIT_NAME = 8'h2C;
  localparam logic [7:0] ADR_PRE_WAIT = 8'h30;
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_EXPOSE = 3'h1;
  localparam logic [2:0] SRC_USB = 3'h2;
  localparam logic [2:0] SRC_FRAME = 3'h3;
  localparam logic [2:0] SRC_WAIT = 3'h4;
  localparam logic [2:0] SRC_CAPTURE = 3'h5;
  localparam logic [2:0] SRC_SOFTWARE = 3'h6;
  localparam logic [2:0] SRC_STROBE = 3'h7;
  localparam logic [1:0] START_OFF = 2'h0;
  localparam logic [1:0] START_INPUT = 2'h1;
  localparam logic [1:0] START_EXPOSURE = 2'h2;
  localparam logic [1:0] START_FRAME = 2'h3;
  localparam logic [1:0] START_DEF = START_EXPOSURE;
  typedef struct packed {
    logic exposure_window;
    logic usb_send_window;
    logic expose_to_readout_window;
    logic awaiting_trigger;
    logic capture_running;
    logic exposure_begin_event;
  } cils_status_t;
  typedef struct packed {
    logic trigger_mode_on;
    logic trigger_from_software;
    logic trigger_from_bidir;
    logic software_trigger;
  } cils_trig_t;
endpackage

//--- hdl/cils_io_line_strobe.sv
// Camera I/O line block: output selection, input noise filters, strobe timer, trigger wait.
// Assumes status and trigger settings come from other blocks on the same clock.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cils_io_line_strobe #(
  parameter int CNT_W = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire cils_pkg::cils_status_t cam_status,
  input wire cils_pkg::cils_trig_t trig_ctl,
  input wire logic input_only_pin_i,
  output logic output_only_pin_o,
  input wire logic bidirectional_pin_i,
  output logic bidirectional_pin_o,
  output logic bidirectional_pin_oe,
  output logic exposure_go,
  output logic frame_start_fault,
  output logic strobe_pulse
);
  import cils_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LAG, ST_PULSE} cils_state_t;

  function automatic logic [31:0] ns_to_cyc(input logic [31:0] ns);
    ns_to_cyc = (ns + 32'(CLK_PERIOD_NS - 1)) / 32'(CLK_PERIOD_NS);
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction

  function automatic logic [CNT_W-1:0] units_to_cyc(input logic [31:0] u);
    units_to_cyc = CNT_W'(u * 32'(UNIT_CYC));
  endfunction

  logic line_pick_q;
  logic [2:0] choice1_q;
  logic [2:0] choice2_q;
  logic bidir_out_q;
  logic [2:0] invert_q;
  logic [2:1] sw_level_q;
  logic [31:0] glitch_ns_q;
  logic [31:0] glitch_cyc_q;
  logic [31:0] blank_ns_q;
  logic [31:0] blank_cyc_q;
  logic [31:0] width_q;
  logic [31:0] lag_q;
  logic [31:0] pre_wait_q;
  logic [1:0] start_choice_q;
  logic [31:0] rdata_q;

  logic [1:0] raw_in;
  logic [31:0] integ_q [2];
  logic [1:0] integ_out_q;
  logic [31:0] blank_cnt_q [2];
  logic [1:0] filt_q;
  logic [1:0] filt_prev_q;
  logic [1:0] line_act;
  logic [1:0] line_rise;

  logic out1;
  logic out2;
  logic hw_edge;
  logic sw_edge;
  logic trig_edge;
  logic trig_ok;
  logic [CNT_W-1:0] wait_cnt_q;
  logic waiting_q;
  logic exposure_go_q;
  logic fault_q;
  logic exp_start;
  logic start_evt;
  cils_state_t state_q;
  logic [CNT_W-1:0] tcnt_q;
  logic [CNT_W-1:0] width_cyc;
  logic [CNT_W-1:0] lag_cyc;

  assign width_cyc = units_to_cyc(width_q);
  assign lag_cyc = units_to_cyc(lag_q);

  // Register writes.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_pick_q <= 1'b0;
      choice1_q <= SRC_OFF;
      choice2_q <= SRC_OFF;
      bidir_out_q <= 1'b0;
      invert_q <= 3'h0;
      sw_level_q <= 2'h0;
      glitch_ns_q <= GLITCH_DEF_NS;
      glitch_cyc_q <= ns_to_cyc(GLITCH_DEF_NS);
      blank_ns_q <= BLANK_DEF_NS;
      blank_cyc_q <= ns_to_cyc(BLANK_DEF_NS);
      width_q <= 32'h00000000;
      lag_q <= 32'h00000000;
      pre_wait_q <= 32'h00000000;
      start_choice_q <= START_DEF;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADR_LINE_PICK: line_pick_q <= reg_wdata[0];
        ADR_SIGNAL_CHOICE: begin
          if (line_pick_q) begin
            choice2_q <= reg_wdata[2:0];
          end else begin
            choice1_q <= reg_wdata[2:0];
          end
        end
        ADR_PIN_DIR: bidir_out_q <= reg_wdata[2];
        ADR_INVERT: invert_q <= reg_wdata[2:0];
        ADR_SW_LEVEL: sw_level_q <= reg_wdata[2:1];
        ADR_INTEGRATOR: begin
          glitch_ns_q <= clamp(reg_wdata, GLITCH_MAX_NS);
          glitch_cyc_q <= ns_to_cyc(clamp(reg_wdata, GLITCH_MAX_NS));
        end
        ADR_BLANKING: begin
          blank_ns_q <= clamp(reg_wdata, BLANK_MAX_NS);
          blank_cyc_q <= ns_to_cyc(clamp(reg_wdata, BLANK_MAX_NS));
        end
        ADR_STROBE_WIDTH: width_q <= clamp(reg_wdata, TIME_MAX_UNITS);
        ADR_STROBE_LAG: lag_q <= clamp(reg_wdata, TIME_MAX_UNITS);
        ADR_PRE_WAIT: pre_wait_q <= clamp(reg_wdata, TIME_MAX_UNITS);
        ADR_STROBE_START: start_choice_q <= reg_wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads; data stand in the cycle after the strobe only.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADR_LINE_PICK: rdata_q <= {31'h00000000, line_pick_q};
        ADR_SIGNAL_CHOICE: rdata_q <= {29'h00000000, line_pick_q ? choice2_q : choice1_q};
        ADR_PIN_DIR: rdata_q <= {29'h00000000, bidir_out_q, 2'h2};
        ADR_INVERT: rdata_q <= {29'h00000000, invert_q};
        ADR_READBACK: begin
          rdata_q <= {29'h00000000, bidir_out_q ? out2 : line_act[1], out1, line_act[0]};
        end
        ADR_SW_LEVEL: rdata_q <= {29'h00000000, sw_level_q, 1'b0};
        ADR_INTEGRATOR: rdata_q <= glitch_ns_q;
        ADR_BLANKING: rdata_q <= blank_ns_q;
        ADR_STROBE_WIDTH: rdata_q <= width_q;
        ADR_STROBE_LAG: rdata_q <= lag_q;
        ADR_STROBE_START: rdata_q <= {30'h00000000, start_choice_q};
        ADR_UNIT_NAME: rdata_q <= STROBE_UNIT_NAME;
        ADR_PRE_WAIT: rdata_q <= pre_wait_q;
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata = rdata_q;

  // Pin synchronisers; a level is taken once the second and third stages agree.
  assign raw_in = {bidirectional_pin_i, input_only_pin_i};
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        integ_q[i] <= 32'h00000000;
      end
      integ_out_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          if (s3_q[i] && integ_q[i] < glitch_cyc_q) begin
            integ_q[i] <= integ_q[i] + 32'h00000001;
          end else if (!s3_q[i] && integ_q[i] != 32'h00000000) begin
            integ_q[i] <= integ_q[i] - 32'h00000001;
          end
        end
        if (integ_q[i] >= glitch_cyc_q) begin
          integ_out_q[i] <= 1'b1;
        end else if (integ_q[i] == 32'h00000000) begin
          integ_out_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        blank_cnt_q[i] <= 32'h00000000;
      end
      filt_q <= 2'h0;
      filt_prev_q <= 2'h0;
    end else begin
      filt_prev_q <= line_act;
      for (int i = 0; i < 2; i++) begin
        if (blank_cnt_q[i] != 32'h00000000) begin
          blank_cnt_q[i] <= blank_cnt_q[i] - 32'h00000001;
        end else if (integ_out_q[i] != filt_q[i]) begin
          filt_q[i] <= integ_out_q[i];
          blank_cnt_q[i] <= blank_cyc_q;
        end
      end
    end
  end

  assign line_act = filt_q ^ {invert_q[2], invert_q[0]};
  assign line_rise = line_act & ~filt_prev_q;

  function automatic logic pick(input logic [2:0] c, input logic sw);
    unique case (c)
      SRC_EXPOSE: pick = cam_status.exposure_window;
      SRC_USB: pick = cam_status.usb_send_window;
      SRC_FRAME: pick = cam_status.expose_to_readout_window;
      SRC_WAIT: pick = cam_status.awaiting_trigger;
      SRC_CAPTURE: pick = cam_status.capture_running;
      SRC_SOFTWARE: pick = sw;
      SRC_STROBE: pick = strobe_pulse;
      default: pick = 1'b0;
    endcase
  endfunction

  logic out1_q;
  logic out2_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      out1_q <= pick(choice1_q, sw_level_q[1]) ^ invert_q[1];
      out2_q <= pick(choice2_q, sw_level_q[2]) ^ invert_q[2];
    end
  end
  assign out1 = out1_q;
  assign out2 = out2_q;
  assign output_only_pin_o = out1;
  assign bidirectional_pin_o = out2;
  assign bidirectional_pin_oe = bidir_out_q;

  assign hw_edge = trig_ctl.trigger_from_bidir ? line_rise[1] : line_rise[0];
  assign sw_edge = trig_ctl.software_trigger;
  assign trig_edge = trig_ctl.trigger_mode_on &&
                     (trig_ctl.trigger_from_software ? sw_edge : hw_edge);
  assign trig_ok = trig_edge && cam_status.awaiting_trigger && !waiting_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waiting_q <= 1'b0;
      wait_cnt_q <= '0;
      exposure_go_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      exposure_go_q <= 1'b0;
      fault_q <= trig_edge && !trig_ok;
      if (trig_ok) begin
        if (pre_wait_q == 32'h00000000) begin
          exposure_go_q <= 1'b1;
        end else begin
          waiting_q <= 1'b1;
          wait_cnt_q <= units_to_cyc(pre_wait_q) - CNT_W'(1);
        end
      end else if (waiting_q) begin
        if (wait_cnt_q == '0) begin
          waiting_q <= 1'b0;
          exposure_go_q <= 1'b1;
        end else begin
          wait_cnt_q <= wait_cnt_q - CNT_W'(1);
        end
      end
    end
  end
  assign exposure_go = exposure_go_q;
  assign frame_start_fault = fault_q;

  assign exp_start = trig_ctl.trigger_mode_on ? exposure_go_q : cam_status.exposure_begin_event;

  always_comb begin
    unique case (start_choice_q)
      START_INPUT: start_evt = line_rise[0] && trig_ctl.trigger_mode_on &&
                               !trig_ctl.trigger_from_software;
      START_EXPOSURE: start_evt = exp_start;
      START_FRAME: start_evt = trig_ok;
      default: start_evt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      tcnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_evt && lag_cyc != '0) begin
            state_q <= ST_LAG;
            tcnt_q <= lag_cyc - CNT_W'(1);
          end else if (start_evt && width_cyc != '0) begin
            state_q <= ST_PULSE;
            tcnt_q <= width_cyc - CNT_W'(1);
          end
        end
        ST_LAG: begin
          if (tcnt_q != '0) begin
            tcnt_q <= tcnt_q - CNT_W'(1);
          end else if (width_cyc != '0) begin
            state_q <= ST_PULSE;
            tcnt_q <= width_cyc - CNT_W'(1);
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_PULSE: begin
          if (tcnt_q != '0) begin
            tcnt_q <= tcnt_q - CNT_W'(1);
          end else begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
  assign strobe_pulse = (state_q == ST_PULSE);
endmodule

//--- test/cils_checker.sv
// Checker of the camera I/O line block, bound to its top module.
// Assumes no timer width is rewritten while a strobe pulse runs.
`timescale 1ns/1ps
module cils_checker
  import cils_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire cils_pkg::cils_status_t cam_status,
  input wire cils_pkg::cils_trig_t trig_ctl,
  input wire logic output_only_pin_o,
  input wire logic bidirectional_pin_oe,
  input wire logic exposure_go,
  input wire logic strobe_pulse
);
  logic pick_q, inv_q, sw_q, dir_q, exp_q;
  logic [2:0] src_q;
  logic [1:0] start_q;
  logic [31:0] width_q, lag_q, hi_q;
  logic [7:0] src_vec;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  assign src_vec = {strobe_pulse, sw_q, cam_status[1], cam_status[2], cam_status[3],
    cam_status[4], cam_status[5], 1'b0};
  // Shadow of the settings that the output-only pin, the bidirectional pin enable and the timer use.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pick_q <= 1'b0;
      src_q <= SRC_OFF;
      inv_q <= 1'b0;
      sw_q <= 1'b0;
      dir_q <= 1'b0;
      width_q <= 32'h0;
      lag_q <= 32'h0;
      start_q <= START_DEF;
    end else if (reg_wr) begin
      case (reg_addr)
        ADR_LINE_PICK: pick_q <= reg_wdata[0];
        ADR_SIGNAL_CHOICE: if (!pick_q) src_q <= reg_wdata[2:0];
        ADR_INVERT: inv_q <= reg_wdata[1];
        ADR_SW_LEVEL: sw_q <= reg_wdata[1];
        ADR_PIN_DIR: dir_q <= reg_wdata[2];
        ADR_STROBE_WIDTH: width_q <= reg_wdata;
        ADR_STROBE_LAG: lag_q <= reg_wdata;
        ADR_STROBE_START: start_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) exp_q <= 1'b0;
    else exp_q <= src_vec[src_q];
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) hi_q <= 32'h0;
    else hi_q <= strobe_pulse ? hi_q + 32'h1 : 32'h0;
  end
  sequence s_readback;
    reg_rd && reg_addr == ADR_READBACK ##1 $stable(output_only_pin_o);
  endsequence
  sequence s_quiet_start;
    cam_status.exposure_begin_event && !trig_ctl.trigger_mode_on && start_q == START_EXPOSURE
      && lag_q == 32'h0 && width_q != 32'h0 && !strobe_pulse;
  endsequence
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  property p_unit_name;
    reg_rd && reg_addr == ADR_UNIT_NAME |=> reg_rdata == STROBE_UNIT_NAME;
  endproperty
  property p_dir_fixed;
    reg_rd && reg_addr == ADR_PIN_DIR |=> reg_rdata[1:0] == 2'h2;
  endproperty
  property p_oe_dir;
    $stable(dir_q) |-> bidirectional_pin_oe == dir_q;
  endproperty
  property p_out_mux;
    $stable(inv_q) |-> output_only_pin_o == (exp_q ^ inv_q);
  endproperty
  property p_readback;
    s_readback |-> reg_rdata[1] == output_only_pin_o;
  endproperty
  property p_strobe_width;
    $fell(strobe_pulse) |-> hi_q == {width_q[30:0], 1'b0};
  endproperty
  property p_strobe_now;
    s_quiet_start |=> strobe_pulse;
  endproperty
  property p_go_pulse;
    exposure_go |=> !exposure_go;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_unit_name: assert property (p_unit_name) else $error("unit name wrong");
  a_dir_fixed: assert property (p_dir_fixed) else $error("fixed directions wrong");
  a_oe_dir: assert property (p_oe_dir) else $error("enable differs from setting");
  a_out_mux: assert property (p_out_mux) else $error("output pin wrong");
  a_readback: assert property (p_readback) else $error("readback wrong");
  a_strobe_width: assert property (p_strobe_width) else $error("pulse width wrong");
  a_strobe_now: assert property (p_strobe_now) else $error("pulse late");
  a_go_pulse: assert property (p_go_pulse) else $error("start not a pulse");
endmodule

bind cils_io_line_strobe cils_checker #(.CNT_W(CNT_W)) chk_u (.ref_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cam_status, .trig_ctl, .output_only_pin_o,
  .bidirectional_pin_oe, .exposure_go, .strobe_pulse);

//--- test/cils_far_side.sv
// Far side model: trigger source on the input pin, pull-up on the shared pin.
// Assumes fire is a one-cycle request made on the rising clock edge.
`timescale 1ns/1ps
module cils_far_side (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic awaiting,
  input wire logic early,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic trig_pin,
  output logic bidir_level
);
  int hold = 0;
  // trigger only while waiting, unless told to misbehave.
  always @(posedge ref_clk) begin
    if (fire && (awaiting || early)) hold <= 40;
    else if (hold != 0) hold <= hold - 1;
  end
  assign trig_pin = hold != 0;
  assign bidir_level = pin_oe ? pin_o : 1'b1;
endmodule

//--- test/testbench.sv
// Self-checking bench of the camera I/O line block with its far-side model.
// Assumes one 200 MHz clock; register reads are checked from a queue.
`timescale 1ns/1ps
module testbench;
  import cils_pkg::*;
  logic ref_clk, reset_n, reg_wr, reg_rd, in_pin, out_pin, bd_i, bd_o, bd_oe;
  logic go, fault, strobe, fire, early, rd_seen, inv, sw;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  cils_status_t cam_status;
  cils_trig_t trig_ctl;
  logic [31:0] want_q[$];
  int bad_count, comparisons, n, w, l, p;
  logic [7:0] adr[13] = '{ADR_LINE_PICK, ADR_SIGNAL_CHOICE, ADR_PIN_DIR, ADR_INVERT,
    ADR_SW_LEVEL, ADR_INTEGRATOR, ADR_BLANKING, ADR_STROBE_WIDTH, ADR_STROBE_LAG,
    ADR_STROBE_START, ADR_UNIT_NAME, ADR_PRE_WAIT, 8'h3C};
  logic [31:0] dflt[13] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0, GLITCH_DEF_NS, BLANK_DEF_NS,
    32'h0, 32'h0, 32'(START_DEF), STROBE_UNIT_NAME, 32'h0, 32'h0};
  cils_io_line_strobe #(.CNT_W(32)) dut_u (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cam_status, .trig_ctl, .input_only_pin_i(in_pin),
    .output_only_pin_o(out_pin), .bidirectional_pin_i(bd_i), .bidirectional_pin_o(bd_o),
    .bidirectional_pin_oe(bd_oe), .exposure_go(go), .frame_start_fault(fault),
    .strobe_pulse(strobe));
  cils_far_side far_u (.ref_clk, .fire, .awaiting(cam_status.awaiting_trigger), .early,
    .pin_o(bd_o), .pin_oe(bd_oe), .trig_pin(in_pin), .bidir_level(bd_i));
  always #2.5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen) check(reg_rdata, want_q.pop_front());
    rd_seen <= reg_rd;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge ref_clk);
    want_q.push_back(want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic kick(input int which);
    @(posedge ref_clk);
    if (which == 0) cam_status.exposure_begin_event <= 1'b1;
    else if (which == 1) trig_ctl.software_trigger <= 1'b1;
    else fire <= 1'b1;
    @(posedge ref_clk);
    cam_status.exposure_begin_event <= 1'b0;
    trig_ctl.software_trigger <= 1'b0;
    fire <= 1'b0;
  endtask
  function automatic logic sig(input int which);
    return which == 0 ? strobe : which == 1 ? go : fault;
  endfunction
  // Counts falling edges until the chosen output reaches the level, up to the limit.
  task automatic count_until(input int which, input logic lvl, input int lim);
    n = 0;
    @(negedge ref_clk);
    while (sig(which) !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    {reg_wr, reg_rd, fire, early} = 4'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    cam_status = '0;
    trig_ctl = '0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'h163C8AE5));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 13; i++) rd(adr[i], dflt[i]);
    wr(ADR_UNIT_NAME, $urandom());
    rd(ADR_UNIT_NAME, STROBE_UNIT_NAME);
    wr(ADR_INTEGRATOR, 32'hFFFFFFFF);
    rd(ADR_INTEGRATOR, GLITCH_MAX_NS);
    wr(ADR_BLANKING, 32'hFFFFFFFF);
    rd(ADR_BLANKING, BLANK_MAX_NS);
    wr(ADR_PRE_WAIT, 32'hFFFFFFFF);
    rd(ADR_PRE_WAIT, TIME_MAX_UNITS);
    w = $urandom_range(1000, 1);
    wr(ADR_STROBE_LAG, w);
    rd(ADR_STROBE_LAG, w);
    wr(ADR_INTEGRATOR, GLITCH_DEF_NS);
    wr(ADR_BLANKING, BLANK_DEF_NS);
    wr(ADR_PRE_WAIT, 32'h0);
    $display("test registers done");
    for (int s = 0; s < 7; s++) begin
      inv = $urandom_range(1, 0);
      sw = $urandom_range(1, 0);
      wr(ADR_SIGNAL_CHOICE, s);
      wr(ADR_INVERT, {30'h0, inv, 1'b0});
      wr(ADR_SW_LEVEL, {30'h0, sw, 1'b0});
      repeat (4) begin
        @(posedge ref_clk);
        cam_status <= 6'($urandom()) & 6'h3E;
        @(posedge ref_clk);
        @(negedge ref_clk);
        w = {sw, cam_status[1], cam_status[2], cam_status[3], cam_status[4], cam_status[5], 1'b0};
        check(32'(out_pin), 32'(w[s] ^ inv));
      end
    end
    wr(ADR_LINE_PICK, 32'h1);
    wr(ADR_PIN_DIR, 32'h4);
    wr(ADR_SIGNAL_CHOICE, 32'(SRC_SOFTWARE));
    wr(ADR_SW_LEVEL, 32'h4);
    wr(ADR_INVERT, 32'h5);
    repeat (40) @(posedge ref_clk);
    check(32'(bd_oe), 32'h1);
    check(32'(bd_o), 32'h0);
    rd(ADR_PIN_DIR, 32'h6);
    rd(ADR_READBACK, 32'h1);
    wr(ADR_LINE_PICK, 32'h0);
    rd(ADR_SIGNAL_CHOICE, 32'(SRC_SOFTWARE));
    wr(ADR_INVERT, 32'h0);
    wr(ADR_PIN_DIR, 32'h0);
    $display("test output lines done");
    wr(ADR_SIGNAL_CHOICE, 32'(SRC_STROBE));
    for (int i = 0; i < 4; i++) begin
      w = $urandom_range(4, 1);
      l = (i == 0) ? 0 : $urandom_range(3, 1);
      wr(ADR_STROBE_WIDTH, w);
      wr(ADR_STROBE_LAG, l);
      kick(0);
      count_until(0, 1'b1, 200);
      check(n, 2 * l);
      count_until(0, 1'b0, 200);
      check(n, 2 * w - 1);
    end
    wr(ADR_STROBE_START, 32'(START_OFF));
    kick(0);
    count_until(0, 1'b1, 50);
    check(n, 50);
    $display("test strobe timer done");
    repeat (500) @(posedge ref_clk);
    trig_ctl <= 4'hC;
    cam_status <= 6'h04;
    wr(ADR_STROBE_START, 32'(START_EXPOSURE));
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 0 : $urandom_range(3, 1);
      l = $urandom_range(3, 0);
      wr(ADR_PRE_WAIT, p);
      wr(ADR_STROBE_LAG, l);
      kick(1);
      count_until(1, 1'b1, 100);
      check(n, 2 * p);
      count_until(0, 1'b1, 100);
      check(n, 2 * l);
      count_until(0, 1'b0, 100);
    end
    wr(ADR_PRE_WAIT, 32'h0);
    wr(ADR_STROBE_LAG, 32'h0);
    wr(ADR_STROBE_START, 32'(START_FRAME));
    kick(1);
    count_until(0, 1'b1, 100);
    check(32'(n < 4), 32'h1);
    count_until(0, 1'b0, 100);
    @(posedge ref_clk);
    cam_status <= 6'h00;
    kick(1);
    count_until(2, 1'b1, 10);
    check(32'(n < 10), 32'h1);
    count_until(0, 1'b1, 60);
    check(n, 60);
    $display("test software trigger done");
    @(posedge ref_clk);
    trig_ctl <= 4'h8;
    early <= 1'b1;
    wr(ADR_STROBE_START, 32'(START_INPUT));
    kick(2);
    count_until(2, 1'b1, 600);
    check(32'(n < 600), 32'h1);
    count_until(0, 1'b1, 600);
    check(32'(n < 600), 32'h1);
    // Both blanking spans of the first pulse must run out, or the next edge is ignored.
    repeat (1000) @(posedge ref_clk);
    early <= 1'b0;
    cam_status <= 6'h04;
    kick(2);
    count_until(1, 1'b1, 600);
    check(32'(n < 600), 32'h1);
    $display("test hardware trigger done");
    report_and_stop();
  end
endmodule
